// ### rtl/osc_settle_cfg.svh
`ifndef OSC_SETTLE_CFG_SVH
`define OSC_SETTLE_CFG_SVH
`define OSC_SETTLE_STATUS_ADDR  16'hffa3
`define OSC_SETTLE_SELECT_ADDR  16'hffa4
`define OSC_SETTLE_STATUS_RST   8'h00
`define OSC_SETTLE_SELECT_RST   8'h05
`define SEL_2P11                3'h1
`define SEL_2P13                3'h2
`define SEL_2P14                3'h3
`define SEL_2P15                3'h4
`define SEL_2P16                3'h5
`define EXP_2P11                11
`define EXP_2P13                13
`define EXP_2P14                14
`define EXP_2P15                15
`define EXP_2P16                16
`define SETTLE_CNT_W            17
`define STAT_BIT_2P11           4
`define STAT_BIT_2P16           0
`define HALT_BIT                7
`endif

// ### rtl/osc_settle_pkg.sv
package osc_settle_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COUNT,
        ST_DONE
    } settle_state_e;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        bit_op;
        logic [2:0]  bit_idx;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_s;

    typedef struct packed {
        logic        pin_reset;
        logic        power_on_clear;
        logic        low_voltage_detect;
        logic        watchdog_reset;
    } reset_src_s;
endpackage : osc_settle_pkg

// ### rtl/osc_start_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module osc_start_sync (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage_reg;
    logic [2:0] stage_next;
    logic       out_reg;
    logic       out_next;

    always_comb begin
        stage_next = {stage_reg[1:0], async_in};
        out_next   = out_reg;
        if (stage_reg[1] == stage_reg[2]) begin
            out_next = stage_reg[2];
        end
        if (srst) begin
            stage_next = 3'h0;
            out_next   = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        stage_reg <= stage_next;
        out_reg   <= out_next;
    end

    assign sync_out = out_reg;
endmodule : osc_start_sync

// ### rtl/osc_settle_timer.sv
`timescale 1ns/1ps
`include "osc_settle_cfg.svh"
module osc_settle_timer
    import osc_settle_pkg::*;
#(
    parameter int CNT_W = `SETTLE_CNT_W
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire reset_src_s reset_src,
    input  wire reg_req_s   req,
    input  wire logic       stop_exec,
    input  wire logic       stop_release,
    input  wire logic       cpu_on_main_osc,
    input  wire logic       main_osc_control_wr,
    input  wire logic [7:0] main_osc_control_wdata,
    input  wire logic       main_crystal_osc,
    output logic [7:0]      rdata,
    output logic            rvalid,
    output logic            cpu_hold,
    output logic            settle_done
);
    // Oscillator edge tick arrives from the crystal domain; sampled, not clocked on
    logic osc_sync;
    logic osc_prev_reg;
    logic osc_prev_next;
    logic osc_tick;

    osc_start_sync u_sync (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (main_crystal_osc),
        .sync_out (osc_sync)
    );

    assign osc_tick = osc_sync & ~osc_prev_reg;

    settle_state_e    state_reg;
    settle_state_e    state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [4:0]       status_reg;
    logic [4:0]       status_next;
    logic [2:0]       select_reg;
    logic [2:0]       select_next;
    logic             limit_sel_reg;
    logic             limit_sel_next;
    logic             hold_reg;
    logic             hold_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    logic             rvalid_reg;
    logic             rvalid_next;
    logic             done_reg;
    logic             done_next;
    logic             any_reset;
    logic             clear_evt;
    logic             halt_set;
    logic [CNT_W-1:0] limit;

    // Select code to cycle count of the threshold
    function automatic logic [CNT_W-1:0] sel_cycles(input logic [2:0] sel);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        unique case (sel)
            `SEL_2P11: sel_cycles = one << `EXP_2P11;
            `SEL_2P13: sel_cycles = one << `EXP_2P13;
            `SEL_2P14: sel_cycles = one << `EXP_2P14;
            `SEL_2P15: sel_cycles = one << `EXP_2P15;
            default:   sel_cycles = one << `EXP_2P16;
        endcase
    endfunction : sel_cycles

    // Thermometer status from elapsed count
    function automatic logic [4:0] status_of(input logic [CNT_W-1:0] c);
        logic [CNT_W-1:0] one;
        one = {{(CNT_W-1){1'b0}}, 1'b1};
        status_of[`STAT_BIT_2P11]     = c >= (one << `EXP_2P11);
        status_of[`STAT_BIT_2P11 - 1] = c >= (one << `EXP_2P13);
        status_of[`STAT_BIT_2P11 - 2] = c >= (one << `EXP_2P14);
        status_of[`STAT_BIT_2P11 - 3] = c >= (one << `EXP_2P15);
        status_of[`STAT_BIT_2P16]     = c >= (one << `EXP_2P16);
    endfunction : status_of

    assign any_reset = reset_src.pin_reset | reset_src.power_on_clear
                     | reset_src.low_voltage_detect | reset_src.watchdog_reset;
    // A halt write clears status even when the oscillator has already stopped
    assign halt_set  = main_osc_control_wr & main_osc_control_wdata[`HALT_BIT];
    assign clear_evt = any_reset | stop_exec | halt_set;
    // Full count after reset or a restart; select limit from stop execution and after stop release
    assign limit     = limit_sel_reg ? sel_cycles(select_reg)
                                     : sel_cycles(`SEL_2P16);

    always_comb begin
        osc_prev_next  = osc_sync;
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        status_next    = status_reg;
        limit_sel_next = limit_sel_reg;
        hold_next      = hold_reg;
        unique case (state_reg)
            ST_IDLE: begin
                // Start-up delay before the first edge does not count
                if (osc_tick) begin
                    state_next = ST_COUNT;
                    cnt_next   = {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            ST_COUNT: begin
                // Stop at the limit so a long-running oscillator cannot wrap the count
                if (osc_tick && cnt_reg < limit) begin
                    cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
                if (cnt_reg >= limit) begin
                    state_next = ST_DONE;
                    hold_next  = 1'b0;
                end
            end
            ST_DONE: begin
            end
        endcase
        // Bits only ever set once reached, so they stay set until a clear
        status_next = status_reg | status_of((cnt_reg > limit) ? limit : cnt_reg);
        // Restart under the select limit; the hold follows the CPU clock source
        if (stop_release) begin
            limit_sel_next = 1'b1;
            hold_next      = cpu_on_main_osc;
            state_next     = ST_IDLE;
            cnt_next       = '0;
        end
        // A clear outranks a tick in the same cycle: it is a restart, not a set
        if (clear_evt) begin
            state_next     = ST_IDLE;
            cnt_next       = '0;
            status_next    = 5'h00;
            limit_sel_next = stop_exec & ~any_reset;
        end
        if (srst) begin
            osc_prev_next  = 1'b0;
            state_next     = ST_IDLE;
            cnt_next       = '0;
            status_next    = 5'(`OSC_SETTLE_STATUS_RST);
            limit_sel_next = 1'b0;
            hold_next      = 1'b0;
        end
        // Registered from the next state so the pin needs no decode of its own
        done_next = (state_next == ST_DONE);
    end

    always_ff @(posedge mclk) begin
        osc_prev_reg  <= osc_prev_next;
        state_reg     <= state_next;
        cnt_reg       <= cnt_next;
        status_reg    <= status_next;
        limit_sel_reg <= limit_sel_next;
        hold_reg      <= hold_next;
        done_reg      <= done_next;
    end

    // Select register group
    always_comb begin
        select_next = select_reg;
        // Byte writes only; bit operations on the select register are ignored
        if (req.wr && !req.bit_op && req.addr == `OSC_SETTLE_SELECT_ADDR) begin
            select_next = req.wdata[2:0];
        end
        if (srst || any_reset) begin
            select_next = 3'(`OSC_SETTLE_SELECT_RST);
        end
    end

    always_ff @(posedge mclk) begin
        select_reg <= select_next;
    end

    // Read port group; an unmapped address answers zero so software never stalls
    always_comb begin
        rdata_next  = 8'h00;
        rvalid_next = 1'b0;
        if (req.rd) begin
            rvalid_next = 1'b1;
            if (req.addr == `OSC_SETTLE_STATUS_ADDR) begin
                rdata_next = {3'h0, status_reg};
                if (req.bit_op) begin
                    rdata_next = {7'h00, rdata_next[req.bit_idx]};
                end
            end else if (req.addr == `OSC_SETTLE_SELECT_ADDR) begin
                rdata_next = {5'h00, select_reg};
            end
        end
        if (srst) begin
            rdata_next  = 8'h00;
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        rdata_reg  <= rdata_next;
        rvalid_reg <= rvalid_next;
    end

    assign rdata       = rdata_reg;
    assign rvalid      = rvalid_reg;
    assign cpu_hold    = hold_reg;
    assign settle_done = done_reg;
endmodule : osc_settle_timer

// ### verification/osc_settle_timer_properties.sv
`timescale 1ns/1ps
`include "osc_settle_cfg.svh"
module osc_settle_checker
    import osc_settle_pkg::*;
#(
    parameter int CNT_W = `SETTLE_CNT_W
) (
    input wire logic       mclk,
    input wire logic       srst,
    input wire reset_src_s reset_src,
    input wire reg_req_s   req,
    input wire logic       stop_exec,
    input wire logic       main_osc_control_wr,
    input wire logic [7:0] main_osc_control_wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       cpu_hold,
    input wire logic       settle_done
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_rd_stat;
        req.rd && !req.bit_op && req.addr == `OSC_SETTLE_STATUS_ADDR;
    endsequence
    sequence s_rd_sel;
        req.rd && !req.bit_op && req.addr == `OSC_SETTLE_SELECT_ADDR;
    endsequence
    a_read_answer: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!req.rd |=> !rvalid)
        else $error("rvalid without read");
    a_stat_upper_zero: assert property (s_rd_stat |=> rdata[7:5] == 3'h0)
        else $error("status upper bits set");
    a_sel_upper_zero: assert property (s_rd_sel |=> rdata[7:3] == 5'h00)
        else $error("select upper bits set");
    a_bit_read_lsb: assert property (req.rd && req.bit_op |=> rdata[7:1] == 7'h00)
        else $error("bit read not in lsb");
    a_halt_clears: assert property (main_osc_control_wr && main_osc_control_wdata[`HALT_BIT]
        ##2 s_rd_stat |=> rdata == 8'h00) else $error("halt did not clear status");
    a_stop_clears: assert property (stop_exec ##2 s_rd_stat |=> rdata == 8'h00)
        else $error("stop did not clear status");
    a_src_sel_five: assert property ((|reset_src) ##1 !req.wr ##1 s_rd_sel |=> rdata == 8'h05)
        else $error("select not five after reset");
    a_hold_not_done: assert property (cpu_hold |-> !settle_done)
        else $error("cpu held after settling");
endmodule : osc_settle_checker

bind osc_settle_timer osc_settle_checker #(.CNT_W(CNT_W)) i_osc_settle_checker (.mclk, .srst,
    .reset_src, .req, .stop_exec, .main_osc_control_wr, .main_osc_control_wdata, .rdata,
    .rvalid, .cpu_hold, .settle_done);

// ### verification/osc_model.sv
`timescale 1ns/1ps
module osc_model (
    input  wire logic mclk,
    input  wire logic run,
    output logic      osc
);
    logic ph;
    // Held low while stopped, so the start-up delay yields no edges
    always @(posedge mclk) begin
        ph <= run ? ~ph : 1'b0;
        osc <= run ? osc ^ ph : 1'b0;
    end
endmodule : osc_model

// ### verification/tb_osc_settle_timer.sv
`timescale 1ns/1ps
`include "osc_settle_cfg.svh"
module tb_osc_settle_timer;
    import osc_settle_pkg::*;
    localparam logic [15:0] STA = `OSC_SETTLE_STATUS_ADDR;
    localparam logic [15:0] SEL = `OSC_SETTLE_SELECT_ADDR;
    localparam int          P_STOP = 0;
    localparam int          P_REL  = 1;
    localparam int          P_HALT = 2;
    logic       mclk, srst, stop_exec, stop_release, cpu_on_main_osc, osc_run, osc;
    logic       main_osc_control_wr, rvalid, cpu_hold, settle_done;
    logic [7:0] main_osc_control_wdata, rdata, d;
    reset_src_s reset_src;
    reg_req_s   req;
    int         bad_count = 0, n_tests = 0, cyc = 0;
    osc_model i_osc_model (.mclk(mclk), .run(osc_run), .osc(osc));
    osc_settle_timer i_osc_settle_timer (.mclk, .srst, .reset_src, .req, .stop_exec,
        .stop_release, .cpu_on_main_osc, .main_osc_control_wr, .main_osc_control_wdata,
        .main_crystal_osc(osc), .rdata, .rvalid, .cpu_hold, .settle_done);
    initial begin
        mclk = 0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [15:0] a, input logic b, input logic [2:0] i);
        @(negedge mclk);
        req = {1'b1, 1'b0, b, i, a, 8'h00};
        @(negedge mclk);
        req = '0;
        d = (rvalid === 1'b1) ? rdata : 8'hee;
    endtask : rd
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        rd(a, 1'b0, 3'h0);
        chk(d, e);
    endtask : rd_chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic b);
        @(negedge mclk);
        req = {1'b0, 1'b1, b, 3'h0, a, v};
        @(negedge mclk);
        req = '0;
    endtask : wr
    task automatic pulse(input int k);
        @(negedge mclk);
        stop_exec           = (k == P_STOP);
        stop_release        = (k == P_REL);
        main_osc_control_wr = (k == P_HALT);
        @(negedge mclk);
        stop_exec           = 1'b0;
        stop_release        = 1'b0;
        main_osc_control_wr = 1'b0;
    endtask : pulse
    task automatic flags(input logic [1:0] e);
        @(negedge mclk);
        chk({6'h00, cpu_hold, settle_done}, {6'h00, e});
    endtask : flags
    task automatic t_regs;
        rd_chk(SEL, 8'h05);
        wr(SEL, 8'hf9, 1'b0);
        rd_chk(SEL, 8'h01);
        wr(SEL, 8'h02, 1'b1);
        rd_chk(SEL, 8'h01);
        rd_chk(16'hffa0, 8'h00);
    endtask : t_regs
    task automatic t_start;
        repeat (50) @(negedge mclk);
        rd_chk(STA, 8'h00);
        osc_run = 1'b1;
        repeat (2040) @(posedge osc);
        rd_chk(STA, 8'h00);
        repeat (16) @(posedge osc);
        rd_chk(STA, 8'h10);
        rd(STA, 1'b1, 3'h4);
        chk(d, 8'h01);
        repeat (6144) @(posedge osc);
        rd_chk(STA, 8'h18);
    endtask : t_start
    task automatic t_stop;
        cpu_on_main_osc = 1'b1;
        pulse(P_STOP);
        osc_run = 1'b0;
        rd_chk(STA, 8'h00);
        pulse(P_REL);
        repeat (100) @(negedge mclk);
        flags(2'b10);
        osc_run = 1'b1;
        repeat (2040) @(posedge osc);
        flags(2'b10);
        repeat (16) @(posedge osc);
        flags(2'b01);
        rd_chk(STA, 8'h10);
        repeat (6200) @(posedge osc);
        rd_chk(STA, 8'h10);
        main_osc_control_wdata = 8'h80;
        pulse(P_HALT);
        osc_run = 1'b0;
        rd_chk(STA, 8'h00);
        cpu_on_main_osc = 1'b0;
        pulse(P_STOP);
        pulse(P_REL);
        flags(2'b00);
    endtask : t_stop
    task automatic t_rst;
        for (int i = 0; i < 4; i++) begin
            wr(SEL, 8'h01, 1'b0);
            reset_src = 4'h1 << i;
            @(negedge mclk);
            reset_src = '0;
            rd_chk(SEL, 8'h05);
            rd_chk(STA, 8'h00);
        end
    endtask : t_rst
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    initial begin
        srst = 1'b1;
        reset_src = '0;
        req = '0;
        stop_exec = 1'b0;
        stop_release = 1'b0;
        cpu_on_main_osc = 1'b0;
        main_osc_control_wr = 1'b0;
        main_osc_control_wdata = 8'h00;
        osc_run = 1'b0;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        t_regs();
        t_start();
        t_stop();
        t_rst();
        test_done();
    end
endmodule : tb_osc_settle_timer
